// ---- hw/tcvr_cfg.svh ----
/*
 * Offsets, field positions, reset values and timing figures for the
 * transceiver mode and data-phase timing block.
 * Assumes a 32-bit Wishbone register window and a 50 MHz system clock.
 */
`ifndef TCVR_CFG_SVH
`define TCVR_CFG_SVH

// register byte offsets
`define REG_TCVR_MODE      8'h00
`define REG_FAST_RATE      8'h04
`define REG_CONTROL        8'h08
`define REG_STATE_REQ      8'h0c
`define REG_STATUS         8'h10
`define REG_TIMING         8'h14

// reset values
`define TCVR_MODE_RST      32'h0000_0007
`define FAST_RATE_RST      32'h0000_0000

// transceiver mode word
`define MODE_FIELD_W       3
`define MODE_BIT_PIN_A     0
`define MODE_BIT_PIN_B     1
`define MODE_BIT_SUPPORTED 2
`define MODE_FAULT_MON_BIT 31

// control word
`define CTRL_RUN_BIT       0
`define CTRL_IO_LSB        1

// status word
`define STAT_REQ_ERR_BIT   3
`define STAT_FAULT_BIT     4
`define STAT_RATE_OK_BIT   5
`define STAT_RATE_REF_BIT  6
`define STAT_BRS_BIT       7

// fast rate word
`define FORM_NUMERIC       4'h0
`define FORM_CUSTOM        4'h8
`define TQ_MIN_NS          10'd25
`define TQ_MAX_NS          10'd800
`define TQ_STEP_NS         10'd25

// clock
`define CLK_PERIOD_NS      10'd20

// accepted numeric rates and their bit lengths in clocks, rounded down
`define R_200K   28'd200000
`define R_250K   28'd250000
`define R_400K   28'd400000
`define R_500K   28'd500000
`define R_800K   28'd800000
`define R_1M     28'd1000000
`define R_1M25   28'd1250000
`define R_1M6    28'd1600000
`define R_2M     28'd2000000
`define R_2M5    28'd2500000
`define R_4M     28'd4000000
`define R_5M     28'd5000000
`define R_8M     28'd8000000
`define CLK_HZ   32'd50000000

`endif

// ---- hw/tcvr_pkg.sv ----
/*
 * Types shared by the transceiver mode and data-phase timing block.
 * Assumes tcvr_cfg.svh for the numeric constants.
 */
package tcvr_pkg;

    // order gives the request codes 0..4 and the mode field index
    typedef enum logic [2:0] {
        st_normal,
        st_sleep,
        st_sw_wake,
        st_sw_fast,
        st_power_up
    } tcvr_state_e;

    // order gives the operating mode codes 0, 1, 2
    typedef enum logic [1:0] {
        io_classic,
        io_fd,
        io_fd_switched
    } io_mode_e;

    typedef struct packed {
        logic        valid;
        logic        custom;
        logic [2:0]  resync_jump_width;
        logic [4:0]  pre_seg;
        logic [3:0]  post_seg;
        logic [5:0]  prescaler;
        logic [11:0] bit_cycles;
    } fd_timing_s;

endpackage

// ---- hw/can_tcvr_ctrl.sv ----
/*
 * Transceiver mode control and data-phase timing configuration, with a
 * classic Wishbone register slave.
 * Assumes one clock clk_sys at 50 MHz, the transceiver pins routed to
 * pads by the chip top, and a protocol engine using the timing outputs.
 */
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "tcvr_cfg.svh"

module can_tcvr_ctrl #(
    parameter int ADDR_W = 8
) (
    // system
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADDR_W-1:0]    wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // transceiver pins
    output logic                      can_tx,
    input  wire logic                 can_rx,
    output logic                      mode_pin_a,
    output logic                      mode_pin_b,
    input  wire logic                 transceiver_fault_n,
    // protocol engine side
    input  wire logic                 tx_bit,
    output logic                      rx_bit,
    output logic                      rate_switching,
    output tcvr_pkg::fd_timing_s      data_timing
);

    if (ADDR_W < 5) begin : g_bad_addr
        $error("ADDR_W too narrow for the register map");
    end

    logic [31:0]            mode_q;
    logic [31:0]            rate_q;
    logic                   run_q;
    tcvr_pkg::io_mode_e     io_q;
    tcvr_pkg::tcvr_state_e  state_q;
    logic                   req_err_q;
    logic                   rate_ref_q;
    logic                   ack_q;
    logic [31:0]            dat_q;
    logic                   tx_q;
    logic [1:0]             sync1_q;
    logic [1:0]             sync2_q;
    logic [1:0]             sync3_q;
    logic [1:0]             filt_q;
    logic                   pin_a_q;
    logic                   pin_b_q;
    logic                   brs_q;
    tcvr_pkg::fd_timing_s   timing_q;

    // bus decode
    logic        req;
    logic        wr;
    logic [7:0]  adr;
    logic [31:0] wdat;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i;
    assign adr = 8'(wb_adr_i);

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return m;
    endfunction

    // pin synchronisers: bit 0 fault_n, bit 1 rx
    logic        fault_live;
    logic        rx_filt;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
            sync3_q <= 2'h3;
            filt_q  <= 2'h3;
        end else begin
            sync1_q <= {can_rx, transceiver_fault_n};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            // level moves only once two stages agree
            filt_q  <= (~(sync2_q ^ sync3_q) & sync3_q)
                     | ((sync2_q ^ sync3_q) & filt_q);
        end
    end

    assign rx_filt    = filt_q[1];
    // low means fault; ignored unless monitoring enabled
    assign fault_live = mode_q[`MODE_FAULT_MON_BIT] & ~filt_q[0];

    // serial data, registered both ways
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_q <= 1'b1;
        end else begin
            tx_q <= tx_bit;
        end
    end

    // state request check
    logic [2:0]  req_code;
    logic        code_ok;
    logic        supported;
    logic [2:0]  cur_field;
    logic        wake;

    assign req_code = wb_dat_i[2:0];
    assign code_ok  = req_code <= 3'(tcvr_pkg::st_power_up);

    always_comb begin
        supported = 1'b0;
        if (req_code == 3'(tcvr_pkg::st_normal)) begin
            supported = 1'b1;
        end else if (code_ok) begin
            supported = mode_q[3*req_code + `MODE_BIT_SUPPORTED];
        end
    end

    assign wake = (state_q == tcvr_pkg::st_sleep) & ~rx_filt;

    logic wr_req;
    assign wr_req = wr & (adr == `REG_STATE_REQ) & wb_sel_i[0];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= tcvr_pkg::st_normal;
        end else if (wake) begin
            // remote wakeup wins over a request in the same cycle
            state_q <= tcvr_pkg::st_normal;
        end else if (wr_req && supported) begin
            state_q <= tcvr_pkg::tcvr_state_e'(req_code);
        end
    end

    logic wr_status;
    logic clr_req_err;
    logic clr_rate_ref;
    logic rate_wr;
    logic rate_refused;

    assign wr_status    = wr & (adr == `REG_STATUS) & wb_sel_i[0];
    assign clr_req_err  = wr_status & wb_dat_i[`STAT_REQ_ERR_BIT];
    assign clr_rate_ref = wr_status & wb_dat_i[`STAT_RATE_REF_BIT];
    assign rate_wr      = wr & (adr == `REG_FAST_RATE);
    assign rate_refused = rate_wr & run_q;

    // sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            req_err_q <= 1'b0;
        end else if (wr_req && !supported && !wake) begin
            req_err_q <= 1'b1;
        end else if (clr_req_err) begin
            req_err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rate_ref_q <= 1'b0;
        end else if (rate_refused) begin
            rate_ref_q <= 1'b1;
        end else if (clr_rate_ref) begin
            rate_ref_q <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_q <= `TCVR_MODE_RST;
        end else if (wr && adr == `REG_TCVR_MODE) begin
            // reserved bits 30:15 kept at zero
            mode_q <= merge(mode_q, wb_dat_i, wb_sel_i)
                    & 32'h8000_7fff;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rate_q <= `FAST_RATE_RST;
        end else if (rate_wr && !run_q) begin
            rate_q <= merge(rate_q, wb_dat_i, wb_sel_i);
        end
    end

    logic wr_ctrl;
    assign wr_ctrl = wr & (adr == `REG_CONTROL) & wb_sel_i[0];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            run_q <= 1'b0;
            io_q  <= tcvr_pkg::io_classic;
        end else if (wr_ctrl) begin
            run_q <= wb_dat_i[`CTRL_RUN_BIT];
            // mode is fixed while running; code 3 is not a mode
            if (!run_q && wb_dat_i[`CTRL_IO_LSB +: 2] != 2'h3) begin
                io_q <= tcvr_pkg::io_mode_e'(wb_dat_i[`CTRL_IO_LSB +: 2]);
            end
        end
    end

    // mode pins follow the current state's field
    assign cur_field = mode_q[3*state_q +: `MODE_FIELD_W];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_a_q <= 1'b1;
            pin_b_q <= 1'b1;
        end else begin
            pin_a_q <= cur_field[`MODE_BIT_PIN_A];
            pin_b_q <= cur_field[`MODE_BIT_PIN_B];
        end
    end

    // data-phase timing decode
    logic [3:0]  form;
    logic [1:0]  f_sjw;
    logic [3:0]  f_post;
    logic [3:0]  f_pre;
    logic [9:0]  f_tq;
    logic        cust_ok;
    logic [5:0]  presc;
    logic [11:0] num_cycles;
    logic        num_ok;
    logic [4:0]  quanta;
    tcvr_pkg::fd_timing_s timing_d;

    assign form   = rate_q[31:28];
    assign f_sjw  = rate_q[25:24];
    assign f_post = {1'b0, rate_q[22:20]};
    assign f_pre  = rate_q[19:16];
    assign f_tq   = rate_q[9:0];

    // rounded to the nearest clock, as 25 ns steps do not divide 20 ns
    assign presc  = 6'((f_tq + (`CLK_PERIOD_NS >> 1)) / `CLK_PERIOD_NS);

    assign cust_ok = (form == `FORM_CUSTOM)
                   & (rate_q[27:26] == 2'h0)
                   & (rate_q[15:10] == 6'h00)
                   & (rate_q[23] == 1'b0)
                   & (f_pre != 4'h0)
                   & (f_tq >= `TQ_MIN_NS) & (f_tq <= `TQ_MAX_NS)
                   & (f_tq % `TQ_STEP_NS == 10'd0);

    // sync quantum plus both segments, each applied plus one
    assign quanta = 5'd1 + 5'(f_pre) + 5'd1 + 5'(f_post) + 5'd1;

    always_comb begin
        num_ok     = 1'b1;
        num_cycles = 12'h000;
        case (rate_q[27:0])
            `R_200K: num_cycles = 12'(`CLK_HZ / 32'(`R_200K));
            `R_250K: num_cycles = 12'(`CLK_HZ / 32'(`R_250K));
            `R_400K: num_cycles = 12'(`CLK_HZ / 32'(`R_400K));
            `R_500K: num_cycles = 12'(`CLK_HZ / 32'(`R_500K));
            `R_800K: num_cycles = 12'(`CLK_HZ / 32'(`R_800K));
            `R_1M:   num_cycles = 12'(`CLK_HZ / 32'(`R_1M));
            `R_1M25: num_cycles = 12'(`CLK_HZ / 32'(`R_1M25));
            `R_1M6:  num_cycles = 12'(`CLK_HZ / 32'(`R_1M6));
            `R_2M:   num_cycles = 12'(`CLK_HZ / 32'(`R_2M));
            `R_2M5:  num_cycles = 12'(`CLK_HZ / 32'(`R_2M5));
            `R_4M:   num_cycles = 12'(`CLK_HZ / 32'(`R_4M));
            `R_5M:   num_cycles = 12'(`CLK_HZ / 32'(`R_5M));
            `R_8M:   num_cycles = 12'(`CLK_HZ / 32'(`R_8M));
            default: num_ok = 1'b0;
        endcase
    end

    always_comb begin
        timing_d = '0;
        if (form == `FORM_NUMERIC) begin
            timing_d.valid      = num_ok;
            timing_d.prescaler  = 6'h01;
            timing_d.bit_cycles = num_cycles;
        end else if (cust_ok) begin
            timing_d.valid      = 1'b1;
            timing_d.custom     = 1'b1;
            timing_d.resync_jump_width        = 3'(f_sjw) + 3'h1;
            timing_d.post_seg   = f_post + 4'h1;
            timing_d.pre_seg    = 5'(f_pre) + 5'h01;
            timing_d.prescaler  = presc;
            timing_d.bit_cycles = 12'(presc) * 12'(quanta);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            timing_q <= '0;
            brs_q    <= 1'b0;
        end else begin
            timing_q <= timing_d;
            // fast data phase only in switched mode with a good word
            brs_q    <= (io_q == tcvr_pkg::io_fd_switched)
                      & timing_d.valid;
        end
    end

    // read mux and single-cycle acknowledge
    logic [31:0] rdat;
    logic [31:0] status;
    logic [31:0] timing_rd;

    assign status = {24'h0, brs_q, rate_ref_q, timing_q.valid,
                     fault_live, req_err_q, 3'(state_q)};

    // fields fill bits 29:0; the top two read as zero
    assign timing_rd = {2'h0, timing_q.resync_jump_width, timing_q.pre_seg,
                        timing_q.post_seg, timing_q.prescaler,
                        timing_q.bit_cycles};

    always_comb begin
        case (adr)
            // mode word is write-only and reads as zero
            `REG_FAST_RATE: rdat = rate_q;
            `REG_CONTROL:   rdat = {29'h0, 2'(io_q), run_q};
            `REG_STATE_REQ: rdat = {29'h0, 3'(state_q)};
            `REG_STATUS:    rdat = status;
            `REG_TIMING:    rdat = timing_rd;
            default:        rdat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            dat_q <= req ? rdat : 32'h0000_0000;
        end
    end

    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = dat_q;
    assign can_tx         = tx_q;
    assign rx_bit         = rx_filt;
    assign mode_pin_a     = pin_a_q;
    assign mode_pin_b     = pin_b_q;
    assign rate_switching = brs_q;
    assign data_timing    = timing_q;

endmodule

// ---- tb/can_tcvr_ctrl_sva.sv ----
/* Checker for can_tcvr_ctrl: bus answer, pin causes, timing decode.
   Bound from the bench top; sees the block's ports only. */
`timescale 1ns/100ps
module can_tcvr_ctrl_sva (
    // system
    input wire logic                 clk_sys,
    input wire logic                 resetn,
    // bus and pins
    input wire logic                 wb_ack_o,
    input wire logic                 tx_bit,
    input wire logic                 can_tx,
    input wire logic                 rx_bit,
    input wire logic                 mode_pin_a,
    input wire logic                 mode_pin_b,
    // timing
    input wire logic                 rate_switching,
    input wire tcvr_pkg::fd_timing_s data_timing
);
    logic cust;
    assign cust = data_timing.valid & data_timing.custom;

    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_tx_follow: assert property (
        $past(resetn) |-> can_tx == $past(tx_bit))
        else $error("can_tx not tx_bit one clock later");
    // pins move only after a bus write or a dominant level in sleep
    a_pins_cause: assert property (
        $changed({mode_pin_a, mode_pin_b}) |->
            $past(wb_ack_o) || !$past(rx_bit, 2))
        else $error("mode pins moved without cause");
    // flag and decode load from timing_d.valid on the same edge; the check still allows a lag
    a_switch_valid: assert property (
        !data_timing.valid [*3] |-> !rate_switching)
        else $error("switching without valid timing");
    a_resync_range: assert property (
        cust |-> data_timing.resync_jump_width inside {[3'h1:3'h4]})
        else $error("jump width out of range");
    a_seg_range: assert property (
        cust |-> data_timing.post_seg inside {[4'h1:4'h8]} &&
            data_timing.pre_seg inside {[5'h02:5'h10]})
        else $error("segment out of range");
    a_quantum_range: assert property (
        cust |-> data_timing.prescaler inside {[6'h01:6'h28]})
        else $error("prescaler out of range");
    a_bit_length: assert property (
        cust |-> data_timing.bit_cycles == 12'(data_timing.prescaler) *
            (12'h1 + 12'(data_timing.pre_seg) + 12'(data_timing.post_seg)))
        else $error("bit length not sum of quanta");
    a_numeric_len: assert property (
        data_timing.valid && !data_timing.custom |->
            data_timing.prescaler == 6'h01 &&
            data_timing.bit_cycles inside {[12'h006:12'h0fa]})
        else $error("numeric decode out of range");
endmodule

// ---- tb/tcvr_model.sv ----
/* Behavioural model of the external CAN transceiver.
   Assumes the bench moves wake_req and fault_req just after an edge. */
`timescale 1ns/100ps
module tcvr_model (
    // from the block
    input  wire logic can_tx,
    input  wire logic mode_pin_a,
    input  wire logic mode_pin_b,
    // to the block
    output logic      can_rx,
    output logic      transceiver_fault_n,
    // bench control
    input  wire logic wake_req,
    input  wire logic fault_req
);
    // asleep on both pins low: no echo, bus recessive unless woken
    assign can_rx = wake_req ? 1'b0 :
        (!mode_pin_a && !mode_pin_b) ? 1'b1 : can_tx;
    assign transceiver_fault_n = ~fault_req;
endmodule

// ---- tb/can_tcvr_ctrl_tb_top.sv ----
/* Self-checking bench for can_tcvr_ctrl with a transceiver model.
   Assumes tcvr_pkg and tcvr_cfg.svh are compiled ahead of it. */
`timescale 1ns/100ps
`include "tcvr_cfg.svh"
module can_tcvr_ctrl_tb_top;
    logic                 clk_sys, resetn, wb_cyc, wb_stb, wb_we;
    logic [7:0]           wb_adr;
    logic [31:0]          wb_wdat, wb_rdat, rd;
    logic                 wb_ack, can_tx, can_rx, pin_a, pin_b, fault_n;
    logic                 tx_bit, rx_bit, rate_sw, wake_req, fault_req;
    tcvr_pkg::fd_timing_s timing;
    int                   num_errors, num_checks, cycles;
    localparam logic [31:0] MODE_CFG = 32'h0000_5c23;
    // normal field 010, reserved bits 30:16 set
    localparam logic [31:0] MODE_ALT = 32'h7fff_5c22;

    can_tcvr_ctrl #(.ADDR_W(8)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .can_tx(can_tx), .can_rx(can_rx),
        .mode_pin_a(pin_a), .mode_pin_b(pin_b),
        .transceiver_fault_n(fault_n), .tx_bit(tx_bit),
        .rx_bit(rx_bit), .rate_switching(rate_sw), .data_timing(timing));

    tcvr_model peer (
        .can_tx(can_tx), .mode_pin_a(pin_a), .mode_pin_b(pin_b),
        .can_rx(can_rx), .transceiver_fault_n(fault_n),
        .wake_req(wake_req), .fault_req(fault_req));

    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic xfer(input logic we, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        @(posedge clk_sys);
        while (wb_ack !== 1'b1) @(posedge clk_sys);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
            input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic stat_bit(input string nm, input int b, input logic e);
        xfer(1'b0, `REG_STATUS, 32'h0);
        chk(nm, {31'h0, e}, {31'h0, rd[b]});
    endtask

    function automatic logic [31:0] cw(input int j, po, pr, tq);
        return {4'h8, 2'h0, j[1:0], po[3:0], pr[3:0], 6'h00, tq[9:0]};
    endfunction

    task automatic t_reset();
        chk("pins", 32'h3, {30'h0, pin_b, pin_a});
        chk("can_tx", 32'h1, {31'h0, can_tx});
        rdc("rate_word", `REG_FAST_RATE, `FAST_RATE_RST);
        chk("valid", 32'h0, {31'h0, timing.valid});
        rdc("mode_word", `REG_TCVR_MODE, 32'h0);
        rdc("unmapped", 8'h3c, 32'h0);
    endtask

    task automatic t_modes();
        logic [2:0]  code [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h5};
        logic [2:0]  st [6] = '{3'h1, 3'h1, 3'h3, 3'h4, 3'h0, 3'h0};
        logic [31:0] f;
        wr(`REG_TCVR_MODE, MODE_CFG);
        foreach (code[i]) begin
            wr(`REG_STATE_REQ, {29'h0, code[i]});
            rdc("state", `REG_STATE_REQ, {29'h0, st[i]});
            f = MODE_CFG >> (3 * st[i]);
            chk("pins", {30'h0, f[1:0]}, {30'h0, pin_b, pin_a});
            stat_bit("req_err", 3, code[i] != st[i]);
            wr(`REG_STATUS, 32'h8);
        end
        wr(`REG_TCVR_MODE, MODE_ALT);
        rdc("state", `REG_STATE_REQ, 32'h0);
        chk("pins", 32'h2, {30'h0, pin_b, pin_a});
    endtask

    task automatic t_wake();
        wr(`REG_STATE_REQ, 32'h1);
        rdc("state", `REG_STATE_REQ, 32'h1);
        wake_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        wake_req <= 1'b0;
        rdc("state", `REG_STATE_REQ, 32'h0);
        chk("pins", 32'h2, {30'h0, pin_b, pin_a});
    endtask

    task automatic t_fault();
        fault_req <= 1'b1;
        wr(`REG_TCVR_MODE, 32'h0000_5c22);
        repeat (6) @(posedge clk_sys);
        stat_bit("fault", 4, 1'b0);
        wr(`REG_TCVR_MODE, 32'h8000_5c22);
        repeat (6) @(posedge clk_sys);
        stat_bit("fault", 4, 1'b1);
        fault_req <= 1'b0;
        repeat (6) @(posedge clk_sys);
        stat_bit("fault", 4, 1'b0);
    endtask

    task automatic t_link();
        tx_bit <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("rx_bit", 32'h0, {31'h0, rx_bit});
        tx_bit <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("rx_bit", 32'h1, {31'h0, rx_bit});
    endtask

    task automatic t_rates();
        int rate [13] = '{200000, 250000, 400000, 500000, 800000, 1000000,
            1250000, 1600000, 2000000, 2500000, 4000000, 5000000, 8000000};
        logic [31:0]          bad [8];
        logic [31:0]          gd [3];
        tcvr_pkg::fd_timing_s e;
        bad = '{32'd300000, 32'h1000_0000, cw(0, 0, 0, 100),
            cw(0, 0, 1, 30), cw(0, 8, 1, 100), cw(0, 0, 1, 825),
            cw(0, 0, 1, 25) | 32'h0400_0000, cw(0, 0, 1, 25) | 32'h400};
        gd = '{cw(0, 0, 1, 25), cw(3, 7, 15, 800), cw(2, 3, 9, 475)};
        foreach (rate[i]) begin
            wr(`REG_FAST_RATE, 32'(rate[i]));
            repeat (2) @(posedge clk_sys);
            chk("num_ok", 32'h1, {31'h0, timing.valid});
            chk("num_len", `CLK_HZ / rate[i],
                {20'h0, timing.bit_cycles});
        end
        foreach (bad[i]) begin
            wr(`REG_FAST_RATE, bad[i]);
            repeat (2) @(posedge clk_sys);
            chk("bad_ok", 32'h0, {31'h0, timing.valid});
        end
        foreach (gd[i]) begin
            wr(`REG_FAST_RATE, gd[i]);
            repeat (2) @(posedge clk_sys);
            e.valid = 1'b1;
            e.custom = 1'b1;
            e.resync_jump_width = 3'(gd[i][25:24]) + 3'h1;
            e.post_seg = gd[i][23:20] + 4'h1;
            e.pre_seg = 5'(gd[i][19:16]) + 5'h01;
            e.prescaler = 6'((gd[i][9:0] + 10'h00a) / 10'h014);
            e.bit_cycles = 12'(e.prescaler) *
                (12'h1 + 12'(e.pre_seg) + 12'(e.post_seg));
            chk("custom", e, timing);
            rdc("timing_reg", `REG_TIMING, {2'h0, e.resync_jump_width, e.pre_seg,
                e.post_seg, e.prescaler, e.bit_cycles});
        end
        for (int m = 0; m < 3; m++) begin
            wr(`REG_CONTROL, 32'(2 * m));
            wr(`REG_CONTROL, 32'(2 * m + 1));
            repeat (3) @(posedge clk_sys);
            chk("switch", 32'(m == 2), {31'h0, rate_sw});
        end
        wr(`REG_FAST_RATE, 32'd500000);
        rdc("rate_held", `REG_FAST_RATE, gd[2]);
        stat_bit("refused", 6, 1'b1);
        chk("switch", 32'h1, {31'h0, rate_sw});
        wr(`REG_CONTROL, 32'h0);
    endtask

    initial begin
        clk_sys = 1'b0;
        resetn = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_wdat = 32'h0;
        tx_bit = 1'b1;
        wake_req = 1'b0;
        fault_req = 1'b0;
        num_errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_modes();
        t_wake();
        t_fault();
        t_link();
        t_rates();
        give_verdict();
    end
endmodule

bind can_tcvr_ctrl can_tcvr_ctrl_sva chk_i (
    .clk_sys(clk_sys), .resetn(resetn), .wb_ack_o(wb_ack_o),
    .tx_bit(tx_bit), .can_tx(can_tx), .rx_bit(rx_bit),
    .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b),
    .rate_switching(rate_switching), .data_timing(data_timing));
